// File: pkg/fsfc_pkg.sv
// Package of constants for the four-channel fault supervisor
package fsfc_pkg;
  localparam int FSFC_CH = 4;
  localparam int FSFC_CLK_MHZ = 100;
  // Fault codes, high bit then low bit of each channel pair
  localparam logic [1:0] FSFC_CODE_OV = 2'h0;
  localparam logic [1:0] FSFC_CODE_OL = 2'h1;
  localparam logic [1:0] FSFC_CODE_OC = 2'h2;
  localparam logic [1:0] FSFC_CODE_STG = 2'h3;
  // Deglitch and retry times for each 3-bit timing select value
  localparam int FSFC_OL_US [8] = '{120, 30, 60, 240, 120, 30, 60, 240};
  localparam int FSFC_OC_US [8] = '{120, 30, 60, 240, 120, 30, 60, 240};
  localparam int FSFC_STG_US [8] = '{16, 4, 8, 32, 120, 30, 60, 240};
  localparam int FSFC_RETRY_MS [8] = '{16, 4, 8, 32, 16, 4, 8, 32};
  // Microsecond tick: one enable pulse per this many clocks
  localparam int FSFC_TICK_CYC = FSFC_CLK_MHZ;
  localparam logic [2:0] FSFC_TSEL_RST = 3'h0;
  localparam logic [1:0] FSFC_RST_CODE = 2'h0;
endpackage

// File: logic/fsfc_deglitch.sv
// Per-channel deglitch filter counting microsecond ticks
`timescale 1ns/1ps
module fsfc_deglitch (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Timebase and condition
  input wire logic tick_i,
  input wire logic cond_i,
  input wire logic [15:0] limit_i,
  // Result
  output logic valid_o
);
  logic [15:0] cnt_reg;

  // Count while the condition holds; any drop restarts the interval
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !cond_i) begin
      cnt_reg <= 16'h0000; // R23
    end else if (tick_i && cnt_reg < limit_i) begin
      cnt_reg <= cnt_reg + 16'h0001; // R13
    end
  end

  assign valid_o = cond_i && (cnt_reg >= limit_i);
endmodule

// File: logic/fsfc_supervisor.sv
// Fault supervision core for four high-side gate channels
`timescale 1ns/1ps
// Functional notes
// [R1] Input low-high in retry restarts timer, enables
// [R2] No duty-cycle limit on host toggling
// [R3] Interrupt stays low until select falls
// [R4] Host ties select high when unused
// [R5] Fault-only host shifts zero control bits
// [R6] Strapped unused channels never commanded on
// [R7] Any fault latches interrupt low at once
// [R8] Overvoltage forces gates off, latches interrupt
// [R9] Overvoltage clear needs condition gone, no bits
// [R10] Overvoltage sets no channel fault bits
// [R11] Gates follow commands once overvoltage ends
// [R12] Open-load monitored only while fully off
// [R13] Open-load valid after full filter interval
// [R14] Valid open-load latches interrupt, sets code
// [R15] Eight fault bits, two per channel
// [R16] Retry low: open-load channel stays disabled
// [R17] Re-enable needs normal load, on-off-on
// [R18] Retry high: open-load delays gate by retry
// [R19] One shared retry timer, first fault wins
// [R20] Load normal again: no extra retry delay
// [R21] On-command is parallel OR serial bit
// [R22] Faults caught while select high
// [R23] Filter timer clears when indication drops
module fsfc_supervisor
  import fsfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Host side commands
  input wire logic [fsfc_pkg::FSFC_CH-1:0] parallel_ctrl_input_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] serial_ctrl_bits_i,
  input wire logic [2:0] timing_select_i,
  input wire logic retry_mode_select_i,
  input wire logic chip_select_n_i,
  // Analog comparator indications
  input wire logic supply_overvoltage_lockout_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] open_load_cmp_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] over_current_cmp_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] short_to_ground_cmp_i,
  // Outputs
  output logic [fsfc_pkg::FSFC_CH-1:0] gate_drive_out_o,
  output logic fault_interrupt_n_o,
  output logic [2*fsfc_pkg::FSFC_CH-1:0] fault_bits_o
);
  import fsfc_pkg::*;

  typedef enum logic [1:0] {FSFC_IDLE, FSFC_RUN, FSFC_DONE} fsfc_retry_e;

  logic [6:0] tick_cnt_reg;
  logic us_tick_reg;
  logic ms_tick;
  logic [9:0] ms_cnt_reg;
  logic cs_n_d_reg;
  logic cs_fall;
  logic cs_rise;
  logic [FSFC_CH-1:0] cmd;
  logic [FSFC_CH-1:0] cmd_d_reg;
  logic [FSFC_CH-1:0] par_d_reg;
  logic [FSFC_CH-1:0] ol_valid;
  logic [FSFC_CH-1:0] oc_valid;
  logic [FSFC_CH-1:0] stg_valid;
  logic [FSFC_CH-1:0] ol_seen_reg;
  logic [FSFC_CH-1:0] latch_off_reg;
  logic [FSFC_CH-1:0] retry_hold_reg;
  logic [FSFC_CH-1:0] cycle_off_reg;
  logic [FSFC_CH-1:0] gate_next;
  logic [2*FSFC_CH-1:0] fbits_reg;
  logic fault_n_reg;
  logic any_new;
  fsfc_retry_e retry_state_reg;
  logic [5:0] retry_ms_reg;
  logic [15:0] ol_lim;
  logic [15:0] oc_lim;
  logic [15:0] stg_lim;
  logic [5:0] retry_lim;

  // Limits selected by the timing bits; filter tables in microseconds, retry table in milliseconds
  assign ol_lim = 16'(FSFC_OL_US[timing_select_i]);
  assign oc_lim = 16'(FSFC_OC_US[timing_select_i]);
  assign stg_lim = 16'(FSFC_STG_US[timing_select_i]);
  assign retry_lim = 6'(FSFC_RETRY_MS[timing_select_i]);

  // Microsecond enable from the 100 MHz clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick_cnt_reg == 7'(FSFC_TICK_CYC - 1)) begin
      tick_cnt_reg <= 7'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      us_tick_reg <= 1'b0;
    end else begin
      us_tick_reg <= (tick_cnt_reg == 7'(FSFC_TICK_CYC - 1));
    end
  end

  // Millisecond enable derived from the microsecond enable
  // Retry times are whole milliseconds, so a coarse enable is enough
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ms_cnt_reg <= 10'h000;
    end else if (us_tick_reg) begin
      ms_cnt_reg <= ms_tick ? 10'h000 : ms_cnt_reg + 10'h001;
    end
  end
  assign ms_tick = us_tick_reg && (ms_cnt_reg == 10'h3e7);

  // Select edges; inputs are already synchronous
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cs_n_d_reg <= 1'b1;
    end else begin
      cs_n_d_reg <= chip_select_n_i;
    end
  end
  assign cs_fall = cs_n_d_reg && !chip_select_n_i;
  assign cs_rise = !cs_n_d_reg && chip_select_n_i;

  // Effective command is parallel OR serial; no duty limit imposed (R2)
  assign cmd = parallel_ctrl_input_i | serial_ctrl_bits_i; // R21

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_d_reg <= '0;
      par_d_reg <= '0;
    end else begin
      cmd_d_reg <= cmd;
      par_d_reg <= parallel_ctrl_input_i;
    end
  end

  // Per-channel deglitch filters
  genvar g;
  generate
    for (g = 0; g < FSFC_CH; g++) begin : g_ch
      fsfc_deglitch u_ol (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(us_tick_reg),
        .cond_i(open_load_cmp_i[g] && !cmd[g]), // R12
        .limit_i(ol_lim),
        .valid_o(ol_valid[g])
      );
      fsfc_deglitch u_oc (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(us_tick_reg),
        .cond_i(over_current_cmp_i[g] && gate_drive_out_o[g]),
        .limit_i(oc_lim),
        .valid_o(oc_valid[g])
      );
      // Short-to-ground has its own timer, gated by over-current, at a shorter limit for timing selects 0 to 3
      fsfc_deglitch u_stg (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(us_tick_reg),
        .cond_i(over_current_cmp_i[g] && short_to_ground_cmp_i[g] && gate_drive_out_o[g]),
        .limit_i(stg_lim),
        .valid_o(stg_valid[g])
      );
    end
  endgenerate

  assign any_new = |(ol_valid | oc_valid | stg_valid);

  // Fault bits capture faults while select is high; rise clears them.
  // Capture wins over the clear so a same-cycle fault is not lost.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fbits_reg <= {FSFC_CH{FSFC_RST_CODE}};
    end else begin
      for (int i = 0; i < FSFC_CH; i++) begin
        if (stg_valid[i]) begin
          fbits_reg[2*i +: 2] <= FSFC_CODE_STG; // R15
        end else if (oc_valid[i]) begin
          fbits_reg[2*i +: 2] <= FSFC_CODE_OC;
        end else if (ol_valid[i]) begin
          fbits_reg[2*i +: 2] <= FSFC_CODE_OL; // R14
        end else if (cs_rise) begin
          fbits_reg[2*i +: 2] <= FSFC_CODE_OV; // R22
        end
      end
    end
  end
  // Overvoltage leaves the bits untouched, reading as code zero (R10)

  // Interrupt latch: set on any fault, cleared only by select falling
  // Set wins over clear, so a fault in the select-fall cycle keeps it low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fault_n_reg <= 1'b1;
    end else if (any_new || supply_overvoltage_lockout_i) begin
      fault_n_reg <= 1'b0; // R7 R8
    end else if (cs_fall && fbits_reg == '0) begin
      fault_n_reg <= 1'b1; // R3 R9
    end
  end

  // Open-load memory; cleared on the on, off, on re-enable in latched mode, or when the load is normal while off in retry mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ol_seen_reg <= '0;
    end else begin
      for (int i = 0; i < FSFC_CH; i++) begin
        if (ol_valid[i]) begin
          ol_seen_reg[i] <= 1'b1;
        end else if (!retry_mode_select_i && cmd[i] && cycle_off_reg[i]) begin
          ol_seen_reg[i] <= 1'b0; // R17
        end else if (retry_mode_select_i && !open_load_cmp_i[i] && !cmd[i]) begin
          ol_seen_reg[i] <= 1'b0; // R20
        end
      end
    end
  end

  // Latched-off mode tracking the on, off, on sequence
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      latch_off_reg <= '0;
      cycle_off_reg <= '0;
    end else begin
      for (int i = 0; i < FSFC_CH; i++) begin
        // Latching at detection, while the channel is still off, means the
        // next on command never reaches the gate, not even for one cycle.
        // The price: a stale open load needs the full on, off, on sequence
        // even if the load recovered before the host asked again.
        if (!retry_mode_select_i && (oc_valid[i] || stg_valid[i] || ol_valid[i])) begin
          latch_off_reg[i] <= 1'b1; // R16
          cycle_off_reg[i] <= 1'b0;
        end else if (latch_off_reg[i] && !cmd[i] && cmd_d_reg[i]) begin
          cycle_off_reg[i] <= 1'b1;
        end else if (latch_off_reg[i] && cmd[i] && cycle_off_reg[i]) begin
          latch_off_reg[i] <= 1'b0; // R17
          cycle_off_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Shared retry timer; started by the first fault only
  // A later fault on another channel while running leaves the count alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      retry_state_reg <= FSFC_IDLE;
      retry_ms_reg <= 6'h00;
    end else begin
      unique case (retry_state_reg)
        FSFC_IDLE: begin
          if (retry_mode_select_i && any_new) begin
            retry_state_reg <= FSFC_RUN; // R18 R19
            retry_ms_reg <= 6'h00;
          end
        end
        FSFC_RUN: begin
          if (|(parallel_ctrl_input_i & ~par_d_reg & retry_hold_reg)) begin
            retry_ms_reg <= 6'h00; // R1
          end else if (ms_tick) begin
            if (retry_ms_reg + 6'h01 >= retry_lim) begin
              retry_state_reg <= FSFC_DONE;
            end
            retry_ms_reg <= retry_ms_reg + 6'h01;
          end
        end
        FSFC_DONE: begin
          retry_state_reg <= FSFC_IDLE;
        end
      endcase
    end
  end

  // Channels held by the retry timer in auto-retry mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      retry_hold_reg <= '0;
    end else begin
      for (int i = 0; i < FSFC_CH; i++) begin
        if (retry_mode_select_i && (oc_valid[i] || stg_valid[i] || ol_valid[i])) begin
          retry_hold_reg[i] <= 1'b1; // R18
        end else if (parallel_ctrl_input_i[i] && !par_d_reg[i]) begin
          retry_hold_reg[i] <= 1'b0; // R1
        end else if (retry_state_reg == FSFC_DONE || !retry_mode_select_i) begin
          retry_hold_reg[i] <= 1'b0;
        end else if (!ol_seen_reg[i] && !oc_valid[i] && !stg_valid[i]
                     && !over_current_cmp_i[i] && !cmd[i]) begin
          retry_hold_reg[i] <= 1'b0; // R20
        end
      end
    end
  end

  // Gate outputs: overvoltage blanks all without latching
  always_comb begin
    gate_next = cmd & ~latch_off_reg & ~retry_hold_reg;
    if (supply_overvoltage_lockout_i) begin
      gate_next = '0; // R8 R11
    end
  end

  // Deglitched on-state faults cut the gate at the same edge as the latch
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gate_drive_out_o <= '0;
    end else begin
      gate_drive_out_o <= gate_next & ~(oc_valid | stg_valid);
    end
  end

  // Registered copies keep every top-level output straight off a flop
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fault_interrupt_n_o <= 1'b1;
      fault_bits_o <= '0;
    end else begin
      fault_interrupt_n_o <= fault_n_reg;
      fault_bits_o <= fbits_reg; // R15
    end
  end
endmodule

// File: verification/fsfc_supervisor_chk.sv
// Port checker for the fault supervisor
`timescale 1ns/1ps
module fsfc_supervisor_chk
  import fsfc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Watched inputs
  input wire logic [fsfc_pkg::FSFC_CH-1:0] parallel_ctrl_input_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] serial_ctrl_bits_i,
  input wire logic chip_select_n_i,
  input wire logic supply_overvoltage_lockout_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] open_load_cmp_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] over_current_cmp_i,
  input wire logic [fsfc_pkg::FSFC_CH-1:0] short_to_ground_cmp_i,
  // Watched outputs
  input wire logic [fsfc_pkg::FSFC_CH-1:0] gate_drive_out_o,
  input wire logic fault_interrupt_n_o,
  input wire logic [2*fsfc_pkg::FSFC_CH-1:0] fault_bits_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Effective command per channel
  wire logic [FSFC_CH-1:0] cmd = parallel_ctrl_input_i | serial_ctrl_bits_i;
  wire logic no_cmp = (open_load_cmp_i | over_current_cmp_i | short_to_ground_cmp_i) == 4'h0;

  supply_overvoltage_lockout_gates_off_a: assert property (
    supply_overvoltage_lockout_i |=> gate_drive_out_o == 4'h0) else $error("gate on in lockout");
  supply_overvoltage_lockout_flag_low_a: assert property (
    supply_overvoltage_lockout_i |-> ##2 !fault_interrupt_n_o) else $error("lockout not flagged");
  supply_overvoltage_lockout_no_bits_a: assert property (
    supply_overvoltage_lockout_i && fault_bits_o == 8'h00 && no_cmp |=> fault_bits_o == 8'h00)
    else $error("lockout set fault bits");
  // Three quiet select cycles exclude a pending clear
  flag_hold_a: assert property (
    (!fault_interrupt_n_o && chip_select_n_i) [*3] |=> !fault_interrupt_n_o)
    else $error("flag rose without select");
  flag_release_a: assert property (
    $rose(fault_interrupt_n_o) |-> $past(fault_bits_o) == 8'h00
      && !$past(supply_overvoltage_lockout_i)) else $error("flag cleared too early");
  open_off_only_a: assert property (
    fault_bits_o[5:4] == 2'h1 && $past(fault_bits_o[5:4]) != 2'h1 |-> !$past(cmd[2], 4))
    else $error("open load seen while on");
  gate_cmd_a: assert property (
    (gate_drive_out_o & ~$past(cmd)) == 4'h0) else $error("gate on without command");
  supply_overvoltage_lockout_release_a: assert property (
    $fell(supply_overvoltage_lockout_i) && fault_bits_o == 8'h00 |=> gate_drive_out_o == $past(cmd))
    else $error("gates stuck after lockout");
  bits_flag_a: assert property (
    fault_bits_o != 8'h00 |=> !fault_interrupt_n_o) else $error("bits set, flag high");
endmodule

bind fsfc_supervisor fsfc_supervisor_chk fsfc_supervisor_chk_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .parallel_ctrl_input_i(parallel_ctrl_input_i),
  .serial_ctrl_bits_i(serial_ctrl_bits_i), .chip_select_n_i(chip_select_n_i),
  .supply_overvoltage_lockout_i(supply_overvoltage_lockout_i), .open_load_cmp_i(open_load_cmp_i),
  .over_current_cmp_i(over_current_cmp_i), .short_to_ground_cmp_i(short_to_ground_cmp_i),
  .gate_drive_out_o(gate_drive_out_o), .fault_interrupt_n_o(fault_interrupt_n_o),
  .fault_bits_o(fault_bits_o));

// File: verification/fsfc_host_model.sv
// Host controller model: channel commands and fault readout
`timescale 1ns/1ps
module fsfc_host_model
  import fsfc_pkg::*;
#(
  parameter int SEL_LOW_CYC = 4
) (
  // Clock
  input wire logic ref_clk_i,
  // Commands toward the supervisor
  output logic [FSFC_CH-1:0] parallel_ctrl_input_o,
  output logic [FSFC_CH-1:0] serial_ctrl_bits_o,
  output logic chip_select_n_o
);
  // Idle: select high keeps the serial port disabled, control bits zero
  initial begin
    parallel_ctrl_input_o = '0;
    serial_ctrl_bits_o = '0;
    chip_select_n_o = 1'b1;
  end
  // Every channel has a real load here, so any may be commanded
  task automatic set_cmd(input logic [FSFC_CH-1:0] par, input logic [FSFC_CH-1:0] ser);
    @(negedge ref_clk_i);
    parallel_ctrl_input_o = par;
    serial_ctrl_bits_o = ser;
  endtask
  // Readout pulse; a longer low time models a slow host
  task automatic read_faults();
    @(negedge ref_clk_i);
    chip_select_n_o = 1'b0;
    repeat (SEL_LOW_CYC) @(negedge ref_clk_i);
    chip_select_n_o = 1'b1;
    repeat (3) @(negedge ref_clk_i);
  endtask
endmodule

// File: verification/tb_fault_supervisor_four_channel.sv
// Self-checking bench for the fault supervisor
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_fault_supervisor_four_channel;
  import fsfc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] tsel = 3'h1;
  logic retry = 1'b0;
  logic supply_overvoltage_lockout = 1'b0;
  logic [3:0] ol = 4'h0;
  logic [3:0] oc = 4'h0;
  logic [3:0] stg = 4'h0;
  logic [3:0] par, ser, gate;
  logic cs_n, flt_n;
  logic [7:0] bits;
  int err_total = 0;
  int checks_done = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  fsfc_host_model fsfc_host_model_i (.ref_clk_i(ref_clk_i), .parallel_ctrl_input_o(par),
    .serial_ctrl_bits_o(ser), .chip_select_n_o(cs_n));
  // Short-to-ground only counts together with over-current on an on channel
  fsfc_supervisor fsfc_supervisor_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .parallel_ctrl_input_i(par), .serial_ctrl_bits_i(ser), .timing_select_i(tsel),
    .retry_mode_select_i(retry), .chip_select_n_i(cs_n), .supply_overvoltage_lockout_i(supply_overvoltage_lockout),
    .open_load_cmp_i(ol), .over_current_cmp_i(oc), .short_to_ground_cmp_i(stg),
    .gate_drive_out_o(gate), .fault_interrupt_n_o(flt_n), .fault_bits_o(bits));

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Bounded wait for a fault pattern
  task automatic wait_bits(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    while (bits !== exp && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Both command paths, then fast toggling with no duty limit
  task automatic t_cmd();
    for (int i = 0; i < 4; i++) begin
      fsfc_host_model_i.set_cmd(4'h1 << i, 4'h0);
      cyc(2);
      `CHK(gate, 4'h1 << i)
      fsfc_host_model_i.set_cmd(4'h0, 4'h1 << i);
      cyc(2);
      `CHK(gate, 4'h1 << i)
    end
    for (int k = 0; k < 6; k++) begin
      fsfc_host_model_i.set_cmd(k[0] ? 4'hf : 4'h0, 4'h0);
      cyc(1);
      `CHK(gate, k[0] ? 4'hf : 4'h0)
    end
  endtask
  task automatic t_supply_overvoltage_lockout();
    fsfc_host_model_i.set_cmd(4'hf, 4'h0);
    cyc(2);
    supply_overvoltage_lockout = 1'b1;
    cyc(2);
    `CHK(gate, 4'h0)
    cyc(1);
    `CHK(flt_n, 1'b0)
    `CHK(bits, 8'h00)
    fsfc_host_model_i.read_faults();
    `CHK(flt_n, 1'b0)
    supply_overvoltage_lockout = 1'b0;
    cyc(2);
    `CHK(gate, 4'hf)
    fsfc_host_model_i.read_faults();
    `CHK(flt_n, 1'b1)
  endtask
  // Latched-off open load on channel 2; channel 0 is on and not monitored
  task automatic t_ol_latch();
    fsfc_host_model_i.set_cmd(4'h1, 4'h0);
    ol = 4'h5;
    cyc(2000);
    ol = 4'h1;
    cyc(5);
    ol = 4'h5;
    // At most 29 ticks fit in 2850 cycles, so no fault may show yet
    cyc(2850);
    `CHK(bits, 8'h00)
    wait_bits(8'h10, 250);
    `CHK(bits, 8'h10)
    `CHK(flt_n, 1'b0)
    ol = 4'h0;
    fsfc_host_model_i.set_cmd(4'h1, 4'h4);
    cyc(1);
    `CHK(gate, 4'h1)
    cyc(2);
    `CHK(gate, 4'h1)
    `CHK(flt_n, 1'b0)
    fsfc_host_model_i.set_cmd(4'h1, 4'h0);
    cyc(3);
    fsfc_host_model_i.set_cmd(4'h5, 4'h0);
    cyc(3);
    `CHK(gate, 4'h5)
    fsfc_host_model_i.read_faults();
    `CHK(bits, 8'h00)
    `CHK(flt_n, 1'b0)
    fsfc_host_model_i.read_faults();
    `CHK(flt_n, 1'b1)
  endtask
  // Auto-retry hold on channel 1, released by a parallel low-high
  task automatic t_retry();
    fsfc_host_model_i.set_cmd(4'h0, 4'h0);
    retry = 1'b1;
    ol = 4'h2;
    wait_bits(8'h04, 3200);
    `CHK(bits, 8'h04)
    ol = 4'h0;
    fsfc_host_model_i.set_cmd(4'h0, 4'h2);
    cyc(1000);
    `CHK(gate, 4'h0)
    fsfc_host_model_i.set_cmd(4'h2, 4'h2);
    cyc(3);
    `CHK(gate, 4'h2)
    fsfc_host_model_i.read_faults();
    fsfc_host_model_i.read_faults();
    retry = 1'b0;
  endtask
  // Over-current on channel 3 in latched mode, then a short on channel 0
  task automatic t_oc();
    fsfc_host_model_i.set_cmd(4'h8, 4'h0);
    cyc(3);
    oc = 4'h8;
    wait_bits(8'h80, 3200);
    `CHK(bits, 8'h80)
    `CHK(gate, 4'h0)
    oc = 4'h0;
    fsfc_host_model_i.read_faults();
    `CHK(bits, 8'h00)
    fsfc_host_model_i.set_cmd(4'h1, 4'h0);
    cyc(3);
    `CHK(gate, 4'h1)
    oc = 4'h1;
    stg = 4'h1;
    // The short limit needs four ticks, which 300 cycles cannot hold
    cyc(300);
    `CHK(bits, 8'h00)
    wait_bits(8'h03, 300);
    `CHK(bits, 8'h03)
    `CHK(gate, 4'h0)
    `CHK(flt_n, 1'b0)
    oc = 4'h0;
    stg = 4'h0;
  endtask

  initial begin
    cyc(12);
    rst_i = 1'b0;
    `CHK(gate, 4'h0)
    `CHK(flt_n, 1'b1)
    `CHK(bits, 8'h00)
    t_cmd();
    t_supply_overvoltage_lockout();
    t_ol_latch();
    t_retry();
    t_oc();
    close_out();
  end
  // Watchdog well beyond the roughly 12500 cycles the scenarios need
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    close_out();
  end
endmodule
